// File: dv/htp_capture_model.sv
// Trace capture model: rebuilds the serial trace stream into bytes and marks packet starts.
// Assumes one bit per clock while valid is high and a start pulse on the first bit of each packet.
`timescale 1ns/1ps
`default_nettype none
module htp_capture_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic trace_data_in,
  input wire logic trace_valid_in,
  input wire logic trace_sof_in
);
  logic [7:0] shift = 8'h00;
  int nbits = 0;
  int cyc = 0;
  logic [7:0] rx_q[$];
  int sof_q[$];
  always @(posedge clk_in) begin
    cyc++;
    if (sys_rst_in) begin
      nbits = 0;
    end else if (trace_valid_in) begin
      // Realign on every start pulse so one lost bit cannot skew later packets
      if (trace_sof_in) begin
        nbits = 0;
        sof_q.push_back(cyc);
      end
      shift = {trace_data_in, shift[7:1]};
      nbits++;
      if (nbits == 8) begin
        rx_q.push_back(shift);
        nbits = 0;
      end
    end
  end
endmodule : htp_capture_model
`default_nettype wire

// File: dv/hw_trace_event_packetizer_tb_top.sv
// Self-checking bench for the trace packetizer: APB set-up, event stimulus, byte-level checks.
// Assumes the capture model beside it rebuilds the serial stream into bytes.
`timescale 1ns/1ps
`default_nettype none
module hw_trace_event_packetizer_tb_top;
  import htp_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, pc;
  logic fold, loadstore_flag, slp, excovh, instovh, cpu_sleep, exc_v, dtm, dtw, sw_v, ts_v;
  logic [8:0] exc_num;
  logic [1:0] exc_fn, dtc, dts;
  htp_pkt_t sw_pkt, ts_pkt;
  logic sw_ack, ts_ack, tdata, tvalid, tsof;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [2:0] fn_tab [4] = '{3'h2, 3'h6, 3'h3, 3'h1};
  always #4 clk_in = ~clk_in;
  htp_packetizer i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .fold_inc_in(fold), .lsu_inc_in(loadstore_flag), .sleep_inc_in(slp), .exc_ovh_inc_in(excovh),
    .instr_ovh_inc_in(instovh), .cpu_sleep_in(cpu_sleep), .pc_in(pc), .exc_valid_in(exc_v),
    .exc_num_in(exc_num), .exc_action_code_in(exc_fn), .dt_match_in(dtm), .dt_comp_in(dtc),
    .dt_pc_in(32'h87654320), .dt_value_in(32'h1234beef), .dt_size_in(dts), .dt_write_not_read_in(dtw),
    .dt_offset_in(16'h3c5a), .sw_valid_in(sw_v), .sw_pkt_in(sw_pkt), .sw_ack_out(sw_ack),
    .ts_valid_in(ts_v), .ts_pkt_in(ts_pkt), .ts_ack_out(ts_ack), .trace_data_out(tdata),
    .trace_valid_out(tvalid), .trace_sof_out(tsof)
  );
  htp_capture_model i_cap (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .trace_data_in(tdata),
    .trace_valid_in(tvalid), .trace_sof_in(tsof));

  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never re-drives the strobes in this time step
    @(posedge clk_in);
    check(32'(n < 20), 32'h1, "apb answer");
  endtask : apb

  task automatic exc(input logic [8:0] num, input logic [1:0] f, input int k);
    exc_v <= 1'b1;
    exc_num <= num;
    exc_fn <= f;
    repeat (k) @(posedge clk_in);
    exc_v <= 1'b0;
  endtask : exc

  task automatic dt(input logic [1:0] c, input logic [1:0] sz, input logic w);
    dtm <= 1'b1;
    dtc <= c;
    dts <= sz;
    dtw <= w;
    @(posedge clk_in);
    dtm <= 1'b0;
  endtask : dt

  task automatic hold(input logic [4:0] m, input int k);
    {fold, loadstore_flag, slp, excovh, instovh} <= m;
    repeat (k) @(posedge clk_in);
    {fold, loadstore_flag, slp, excovh, instovh} <= 5'h00;
  endtask : hold

  task automatic expect_bytes(input logic [7:0] e[$]);
    int n;
    n = 0;
    while (i_cap.rx_q.size() < e.size() && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    foreach (e[i]) begin
      check(i_cap.rx_q.size() > 0 ? {24'h0, i_cap.rx_q.pop_front()} : 32'hx, {24'h0, e[i]}, "trace byte");
    end
  endtask : expect_bytes

  // Fixed wait is long enough for the longest packet to leave completely
  task automatic quiet(input logic empty);
    repeat (300) @(posedge clk_in);
    if (empty) begin
      check(32'(i_cap.rx_q.size()), 32'h0, "unexpected bytes");
    end
    i_cap.rx_q.delete();
  endtask : quiet

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, fold, loadstore_flag, slp, excovh, instovh, cpu_sleep, exc_v, exc_num,
      exc_fn, dtm, dtc, dts, dtw, sw_v, ts_v, sw_pkt, ts_pkt} = '0;
    // Odd PC: the sample must still show it halfword aligned
    pc = 32'h12345679;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    check(rdata, 32'(CTRL_RST), "ctrl reset value");
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rdata, 32'h0, "unmapped data");
    exc(9'h1a5, 2'h1, 1);
    quiet(1'b1);
    apb(1'b1, REG_CTRL, 32'h1 << CTL_EXCTRC);
    for (int f = 1; f < 4; f++) begin
      exc(9'h1a5, f[1:0], 1);
      expect_bytes('{8'h0e, 8'ha5, {2'h0, f[1:0], 4'h1}});
    end
    exc(9'h1a5, 2'h0, 1);
    quiet(1'b1);
    sw_pkt <= '{data: 80'ha501, len: 4'h2};
    ts_pkt <= '{data: 80'h30, len: 4'h1};
    sw_v <= 1'b1;
    ts_v <= 1'b1;
    fork
      begin
        do begin
          @(posedge clk_in);
        end while (sw_ack !== 1'b1);
        sw_v <= 1'b0;
      end
      begin
        do begin
          @(posedge clk_in);
        end while (ts_ack !== 1'b1);
        ts_v <= 1'b0;
      end
    join_none
    exc(9'h1a5, 2'h1, 1);
    expect_bytes('{8'h01, 8'ha5, 8'h0e, 8'ha5, 8'h11, 8'h30});
    exc(9'h011, 2'h2, 6);
    expect_bytes('{8'h0e, 8'h11, 8'h20, 8'h0e, 8'h11, 8'h20, OVF_BYTE});
    apb(1'b1, REG_CTRL, 32'h3 << (CTL_EV_LO + FLG_SLEEP));
    hold(5'h1f, 256);
    expect_bytes('{8'h05, 8'h0c});
    hold(5'h10, 3);
    apb(1'b0, REG_COUNTS, 32'h0);
    check(rdata, 32'h3, "counter values");
    quiet(1'b1);
    apb(1'b1, REG_CTRL, 32'h0040_1003);
    i_cap.sof_q.delete();
    expect_bytes('{8'h17, 8'h78, 8'h56, 8'h34, 8'h12});
    expect_bytes('{8'h17, 8'h78, 8'h56, 8'h34, 8'h12});
    check(32'(i_cap.sof_q[1] - i_cap.sof_q[0]), 32'd128, "sample interval");
    cpu_sleep <= 1'b1;
    expect_bytes('{8'h15, 8'h00});
    cpu_sleep <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0000_1201);
    i_cap.sof_q.delete();
    expect_bytes('{8'h17, 8'h78, 8'h56, 8'h34, 8'h12});
    expect_bytes('{8'h17, 8'h78, 8'h56, 8'h34, 8'h12});
    check(32'(i_cap.sof_q[1] - i_cap.sof_q[0]), 32'd1024, "slow sample interval");
    apb(1'b1, REG_CTRL, 32'h0);
    quiet(1'b0);
    apb(1'b1, REG_CTRL, 32'h0040_0001);
    expect_bytes('{8'h05, 8'h20});
    apb(1'b1, REG_CTRL, 32'h0);
    quiet(1'b0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, REG_FUNC0 + 8'(4 * c), {29'h0, fn_tab[c]});
    end
    dt(2'h0, 2'h2, 1'b0);
    expect_bytes('{8'h87, 8'hef, 8'hbe, 8'h34, 8'h12});
    dt(2'h1, 2'h0, 1'b0);
    expect_bytes('{8'h5e, 8'h5a, 8'h3c, 8'h95, 8'hef});
    dt(2'h2, 2'h1, 1'b1);
    expect_bytes('{8'h67, 8'h20, 8'h43, 8'h65, 8'h87, 8'hae, 8'hef, 8'hbe});
    dt(2'h3, 2'h0, 1'b0);
    expect_bytes('{8'h77, 8'h20, 8'h43, 8'h65, 8'h87});
    apb(1'b1, REG_FUNC0, 32'h0);
    dt(2'h0, 2'h2, 1'b0);
    quiet(1'b1);
    end_sim();
  end
endmodule : hw_trace_event_packetizer_tb_top
`default_nettype wire

// File: hw/htp_packetizer.sv
// Hardware-source trace packetizer: profiling counters, packet formation, source arbitration, bit serializer.
// Assumes event inputs come from logic on clk_in; instrumentation and timestamp packets arrive preformed.
`timescale 1ns/1ps
`default_nettype none
module htp_packetizer (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fold_inc_in,
  input wire logic lsu_inc_in,
  input wire logic sleep_inc_in,
  input wire logic exc_ovh_inc_in,
  input wire logic instr_ovh_inc_in,
  input wire logic cpu_sleep_in,
  input wire logic [31:0] pc_in,
  input wire logic exc_valid_in,
  input wire logic [8:0] exc_num_in,
  input wire logic [1:0] exc_action_code_in,
  input wire logic dt_match_in,
  input wire logic [1:0] dt_comp_in,
  input wire logic [31:0] dt_pc_in,
  input wire logic [31:0] dt_value_in,
  input wire logic [1:0] dt_size_in,
  input wire logic dt_write_not_read_in,
  input wire logic [15:0] dt_offset_in,
  input wire logic sw_valid_in,
  input wire htp_pkg::htp_pkt_t sw_pkt_in,
  output logic sw_ack_out,
  input wire logic ts_valid_in,
  input wire htp_pkg::htp_pkt_t ts_pkt_in,
  output logic ts_ack_out,
  output logic trace_data_out,
  output logic trace_valid_out,
  output logic trace_sof_out
);
  import htp_pkg::*;

  // Register bus
  logic [CTL_W-1:0] ctrl_r, ctrl_nxt;
  logic [FN_W-1:0] func_r [NUM_COMP];
  logic [FN_W-1:0] func_nxt [NUM_COMP];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;

  // Profiling
  logic [CNT_W-1:0] cnt_r [5];
  logic [CNT_W-1:0] cnt_nxt [5];
  logic [POST_W-1:0] post_r, post_nxt;
  logic [CYC_W-1:0] cyc_r, cyc_nxt;
  logic [NUM_FLG-1:0] flags;
  logic tap_tick, post_fire, evt_fire, pcs_fire, exc_fire, dt_fire;
  logic [4:0] inc;

  // Hardware slot and serializer
  htp_pkt_t hw_pkt_r, hw_pkt_nxt, evt_pkt, exc_pkt, pcs_pkt, dt_pkt;
  logic hw_full_r, hw_full_nxt, ovf_r, ovf_nxt, slot_free, lost;
  htp_ser_state_t st_r, st_nxt;
  logic [PKT_W-1:0] buf_r, buf_nxt;
  logic [BITS_W-1:0] bits_r, bits_nxt;
  logic first_r, first_nxt;
  logic grant_sw, grant_hw, grant_ts;
  logic dout_r, dout_nxt, dval_r, dval_nxt, sof_r, sof_nxt, swack_r, swack_nxt, tsack_r, tsack_nxt;

  wire logic ctl_cyc = ctrl_r[CTL_CYC_ENA];
  wire logic ctl_pcs = ctrl_r[CTL_PCS_ENA];
  wire logic [NUM_FLG-1:0] ev_ena = ctrl_r[CTL_EV_LO +: NUM_FLG];
  wire logic [POST_W-1:0] post_reload = ctrl_r[CTL_POST_LO +: POST_W];

  // Register bus: answers in the second access cycle so read data comes from a flop
  always_comb begin
    logic acc;
    acc = psel_in && penable_in;
    ctrl_nxt = ctrl_r;
    func_nxt = func_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = acc && !pready_r;
    if (acc && !pready_r) begin
      prdata_nxt = '0;
      unique case (paddr_in)
        REG_CTRL: prdata_nxt[CTL_W-1:0] = ctrl_r;
        REG_STATUS: prdata_nxt = {25'h0000000, ovf_r, hw_full_r, st_r == HTP_SEND, post_r};
        REG_COUNTS: prdata_nxt = {cnt_r[3], cnt_r[2], cnt_r[1], cnt_r[0]};
        REG_FUNC0, REG_FUNC0 + 8'h04, REG_FUNC0 + 8'h08, REG_FUNC0 + 8'h0c:
          prdata_nxt[FN_W-1:0] = func_r[paddr_in[3:2]];
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (acc && pready_r && pwrite_in) begin
      if (paddr_in == REG_CTRL) begin
        ctrl_nxt = pwdata_in[CTL_W-1:0];
      end
      if (paddr_in[7:4] == REG_FUNC0[7:4] && paddr_in[1:0] == 2'h0) begin
        func_nxt[paddr_in[3:2]] = pwdata_in[FN_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_r <= CTRL_RST;
      func_r <= '{default: '0};
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      func_r <= func_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Profiling counters and post-scaler
  always_comb begin
    inc = {instr_ovh_inc_in, exc_ovh_inc_in, sleep_inc_in, lsu_inc_in, fold_inc_in};
    cnt_nxt = cnt_r;
    flags = '0;
    for (int i = 0; i < 5; i++) begin
      if (inc[i]) begin
        cnt_nxt[i] = cnt_r[i] + 8'h01;
      end
    end
    flags[FLG_FOLD] = inc[0] && (&cnt_r[0]) && ev_ena[FLG_FOLD];
    flags[FLG_LSU] = inc[1] && (&cnt_r[1]) && ev_ena[FLG_LSU];
    flags[FLG_SLEEP] = inc[2] && (&cnt_r[2]) && ev_ena[FLG_SLEEP];
    flags[FLG_EXC] = inc[3] && (&cnt_r[3]) && ev_ena[FLG_EXC];
    flags[FLG_INSTR] = inc[4] && (&cnt_r[4]) && ev_ena[FLG_INSTR];
    cyc_nxt = ctl_cyc ? cyc_r + 10'h001 : cyc_r;
    // Slow tap divides by the whole cycle counter, fast tap by its low bits
    tap_tick = ctl_cyc && (ctrl_r[CTL_TAP] ? (&cyc_r) : (&cyc_r[TAP_FAST_BITS-1:0]));
    post_fire = tap_tick && (post_r == '0);
    post_nxt = post_r;
    if (tap_tick) begin
      post_nxt = post_fire ? post_reload : post_r - 4'h1;
    end
    flags[FLG_CYC] = post_fire && ev_ena[FLG_CYC] && !ctl_pcs;
    evt_fire = |flags;
    pcs_fire = post_fire && ctl_pcs;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_r <= '{default: '0};
      post_r <= '0;
      cyc_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      post_r <= post_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // Packet formation
  always_comb begin
    logic [1:0] dir;
    logic [3:0] nb;
    logic [39:0] pcp, dvp;
    logic [23:0] offp;
    dir = func_r[dt_comp_in][1:0];
    nb = size_bytes(dt_size_in);
    evt_pkt = '{data: {64'h0, 2'b00, flags, hw_hdr(ID_EVENT, SS_1B)}, len: LEN_EVT};
    exc_fire = ctrl_r[CTL_EXCTRC] && exc_valid_in && exc_action_code_in != EXC_FN_NONE;
    exc_pkt = '{data: {56'h0, 2'b00, exc_action_code_in, 3'b000, exc_num_in[8], exc_num_in[7:0],
                       hw_hdr(ID_EXC, SS_2B)}, len: LEN_EXC};
    if (cpu_sleep_in) begin
      pcs_pkt = '{data: {64'h0, SLEEP_MARK, hw_hdr(ID_PC, SS_1B)}, len: LEN_EVT};
    end else begin
      pcs_pkt = '{data: {40'h0, pc_in[31:1], 1'b0, hw_hdr(ID_PC, SS_4B)}, len: LEN_PC};
    end
    dt_fire = dt_match_in && dir != DT_NONE;
    pcp = {dt_pc_in, hw_hdr(ID_DT_PC | {2'b00, dt_comp_in, 1'b0}, SS_4B)};
    dvp = {dt_value_in, hw_hdr(ID_DT_VAL | {2'b00, dt_comp_in, dt_write_not_read_in},
                                (dt_size_in == 2'h0) ? SS_1B : (dt_size_in == 2'h1) ? SS_2B : SS_4B)};
    offp = {dt_offset_in, hw_hdr(ID_DT_OFF | {2'b00, dt_comp_in, 1'b0}, SS_2B)};
    unique case (dir)
      DT_PC: dt_pkt = '{data: {40'h0, pcp}, len: LEN_PC};
      DT_DATA: dt_pkt = '{data: {40'h0, dvp}, len: 4'h1 + nb};
      default: dt_pkt = '{data: {dvp, pcp}, len: LEN_PC + 4'h1 + nb};
    endcase
    if (func_r[dt_comp_in][FN_OFFSEL] && dir[1]) begin
      dt_pkt = '{data: {16'h0, dvp, offp}, len: LEN_OFF + 4'h1 + nb};
    end
  end

  // Hardware slot: one packet deep; anything that cannot enter becomes an overflow packet
  always_comb begin
    logic [2:0] nfire;
    nfire = {2'b00, evt_fire} + {2'b00, exc_fire} + {2'b00, pcs_fire} + {2'b00, dt_fire};
    slot_free = !hw_full_r || grant_hw;
    hw_full_nxt = hw_full_r && !grant_hw;
    hw_pkt_nxt = hw_pkt_r;
    ovf_nxt = ovf_r;
    lost = 1'b0;
    if (slot_free && ovf_r) begin
      hw_pkt_nxt = '{data: {72'h0, OVF_BYTE}, len: LEN_OVF};
      hw_full_nxt = 1'b1;
      ovf_nxt = 1'b0;
      lost = nfire != 3'h0;
    end else if (slot_free && nfire != 3'h0) begin
      hw_full_nxt = 1'b1;
      hw_pkt_nxt = dt_fire ? dt_pkt : exc_fire ? exc_pkt : pcs_fire ? pcs_pkt : evt_pkt;
      lost = nfire > 3'h1;
    end else begin
      lost = nfire != 3'h0;
    end
    if (lost) begin
      ovf_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hw_pkt_r <= '0;
      hw_full_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      hw_pkt_r <= hw_pkt_nxt;
      hw_full_r <= hw_full_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Arbiter and serializer; grants only while idle, so packets never interleave
  always_comb begin
    logic idle;
    idle = st_r == HTP_IDLE;
    grant_sw = idle && sw_valid_in && !swack_r;
    grant_hw = idle && !grant_sw && hw_full_r && !(sw_valid_in && !swack_r);
    grant_ts = idle && ts_valid_in && !tsack_r && !hw_full_r && !(sw_valid_in && !swack_r);
    st_nxt = st_r;
    buf_nxt = buf_r;
    bits_nxt = bits_r;
    first_nxt = first_r;
    dout_nxt = 1'b0;
    dval_nxt = 1'b0;
    sof_nxt = 1'b0;
    swack_nxt = grant_sw;
    tsack_nxt = grant_ts;
    unique case (st_r)
      HTP_IDLE: begin
        if (grant_sw || grant_hw || grant_ts) begin
          buf_nxt = grant_sw ? sw_pkt_in.data : grant_hw ? hw_pkt_r.data : ts_pkt_in.data;
          bits_nxt = {(grant_sw ? sw_pkt_in.len : grant_hw ? hw_pkt_r.len : ts_pkt_in.len), 3'b000};
          first_nxt = 1'b1;
          st_nxt = HTP_SEND;
        end
      end
      HTP_SEND: begin
        dout_nxt = buf_r[0];
        dval_nxt = 1'b1;
        sof_nxt = first_r;
        first_nxt = 1'b0;
        buf_nxt = buf_r >> 1;
        bits_nxt = bits_r - 7'h01;
        if (bits_r <= 7'h01) begin
          st_nxt = HTP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= HTP_IDLE;
      buf_r <= '0;
      bits_r <= '0;
      first_r <= 1'b0;
      dout_r <= 1'b0;
      dval_r <= 1'b0;
      sof_r <= 1'b0;
      swack_r <= 1'b0;
      tsack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      buf_r <= buf_nxt;
      bits_r <= bits_nxt;
      first_r <= first_nxt;
      dout_r <= dout_nxt;
      dval_r <= dval_nxt;
      sof_r <= sof_nxt;
      swack_r <= swack_nxt;
      tsack_r <= tsack_nxt;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign sw_ack_out = swack_r;
  assign ts_ack_out = tsack_r;
  assign trace_data_out = dout_r;
  assign trace_valid_out = dval_r;
  assign trace_sof_out = sof_r;

  a_sw_over_hw: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r == HTP_IDLE && sw_valid_in && !swack_r |=> sw_ack_out && st_r == HTP_SEND)
    else $error("hardware packet granted over instrumentation");
  a_ts_when_empty: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ts_ack_out |-> !$past(hw_full_r) && !sw_ack_out && (!$past(sw_valid_in) || $past(swack_r)))
    else $error("timestamp granted with queues busy");
  a_hdr_hw_form: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    hw_full_r && hw_pkt_r.data[7:0] != OVF_BYTE |-> hw_pkt_r.data[2] && hw_pkt_r.data[1:0] != 2'b00)
    else $error("bad hardware header");
  a_exc_code_ok: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    hw_full_r && hw_pkt_r.data[7:0] == hw_hdr(ID_EXC, SS_2B) |-> hw_pkt_r.data[21:20] != EXC_FN_NONE)
    else $error("exception packet with invalid code");
  a_lsb_first: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r == HTP_SEND |=> trace_valid_out && trace_data_out == $past(buf_r[0])) else $error("bit order wrong");
  a_pkt_unbroken: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r == HTP_SEND && bits_r > 7'h01 |=> st_r == HTP_SEND && bits_r == $past(bits_r) - 7'h01)
    else $error("packet interrupted");
  a_ovf_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    lost |=> ovf_r ##1 (ovf_r || (hw_full_r && hw_pkt_r.data[7:0] == OVF_BYTE)))
    else $error("lost packet without overflow");
  a_post_reload: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    post_fire |=> post_r == $past(post_reload)) else $error("post-scaler did not reload");
  a_apb_answer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    psel_in && penable_in && !pready_out |=> pready_out) else $error("bus answer late");

endmodule : htp_packetizer
`default_nettype wire

// File: hw/htp_pkg.sv
// Constants, packet carrier and state types of the hardware trace packetizer.
// Assumes one processor clock and a synchronous active-high reset around it.
package htp_pkg;

  localparam int PKT_W = 80;
  localparam int LEN_W = 4;
  localparam int BITS_W = 7;
  localparam int CNT_W = 8;
  localparam int POST_W = 4;
  localparam int CYC_W = 10;
  localparam int NUM_COMP = 4;

  typedef struct packed {
    logic [PKT_W-1:0] data;
    logic [LEN_W-1:0] len;
  } htp_pkt_t;

  typedef enum {HTP_IDLE, HTP_SEND} htp_ser_state_t;

  localparam logic [4:0] ID_EVENT = 5'h00;
  localparam logic [4:0] ID_EXC = 5'h01;
  localparam logic [4:0] ID_PC = 5'h02;
  localparam logic [4:0] ID_DT_PC = 5'h08;
  localparam logic [4:0] ID_DT_OFF = 5'h09;
  localparam logic [4:0] ID_DT_VAL = 5'h10;

  localparam logic [1:0] SS_1B = 2'h1;
  localparam logic [1:0] SS_2B = 2'h2;
  localparam logic [1:0] SS_4B = 2'h3;
  localparam logic [7:0] OVF_BYTE = 8'h70;
  localparam logic [7:0] SLEEP_MARK = 8'h00;
  localparam logic [1:0] EXC_FN_NONE = 2'h0;

  localparam logic [3:0] LEN_EVT = 4'h2;
  localparam logic [3:0] LEN_EXC = 4'h3;
  localparam logic [3:0] LEN_PC = 4'h5;
  localparam logic [3:0] LEN_OFF = 4'h3;
  localparam logic [3:0] LEN_OVF = 4'h1;

  // Watch control register fields
  localparam int CTL_CYC_ENA = 0;
  localparam int CTL_POST_LO = 1;
  localparam int CTL_TAP = 9;
  localparam int CTL_PCS_ENA = 12;
  localparam int CTL_EXCTRC = 16;
  localparam int CTL_EV_LO = 17;
  localparam int CTL_W = 23;

  // Event flag positions inside the event payload and the enable field
  localparam int FLG_INSTR = 0;
  localparam int FLG_EXC = 1;
  localparam int FLG_SLEEP = 2;
  localparam int FLG_LSU = 3;
  localparam int FLG_FOLD = 4;
  localparam int FLG_CYC = 5;
  localparam int NUM_FLG = 6;

  // Comparator function register: directive and offset select
  localparam logic [1:0] DT_NONE = 2'h0;
  localparam logic [1:0] DT_PC = 2'h1;
  localparam logic [1:0] DT_DATA = 2'h2;
  localparam logic [1:0] DT_PC_DATA = 2'h3;
  localparam int FN_OFFSEL = 2;
  localparam int FN_W = 3;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNTS = 8'h08;
  localparam logic [7:0] REG_FUNC0 = 8'h10;
  localparam logic [CTL_W-1:0] CTRL_RST = '0;

  localparam int TAP_FAST_BITS = 6;

  function automatic logic [7:0] hw_hdr(input logic [4:0] id, input logic [1:0] ss);
    hw_hdr = {id, 1'b1, ss};
  endfunction : hw_hdr

  function automatic logic [3:0] size_bytes(input logic [1:0] sz);
    size_bytes = (sz == 2'h0) ? 4'h1 : (sz == 2'h1) ? 4'h2 : 4'h4;
  endfunction : size_bytes

endpackage : htp_pkg
